//--- src/timer_count_register_pkg.sv
// timer package: register map, field layout, reset values, types
// ============================================================
package timer_count_register_pkg;

    // ============================================================
    // register byte addresses
    localparam logic [3:0] TIMER_COUNT_REGISTER_ADDR_COUNT_LOW   = 4'h0;
    localparam logic [3:0] TIMER_COUNT_REGISTER_ADDR_HIGH_BUFFER = 4'h4;
    localparam logic [3:0] TIMER_COUNT_REGISTER_ADDR_IRQ_CONTROL = 4'h8;
    localparam logic [3:0] TIMER_COUNT_REGISTER_ADDR_TIMER_CTRL  = 4'hC;

    // ============================================================
    // field positions
    localparam int TIMER_COUNT_REGISTER_CTRL_RUN    = 7;
    localparam int TIMER_COUNT_REGISTER_CTRL_WIDTH  = 6;
    localparam int TIMER_COUNT_REGISTER_CTRL_SOURCE = 5;
    localparam int TIMER_COUNT_REGISTER_CTRL_EDGE   = 4;
    localparam int TIMER_COUNT_REGISTER_CTRL_BYPASS = 3;
    localparam int TIMER_COUNT_REGISTER_IRQ_ENABLE  = 5;
    localparam int TIMER_COUNT_REGISTER_IRQ_FLAG    = 2;

    // ============================================================
    // reset values and counts
    localparam logic [7:0] TIMER_COUNT_REGISTER_CTRL_RESET     = 8'hFF;
    localparam logic [7:0] TIMER_COUNT_REGISTER_HIGH_RESET     = 8'h00;
    localparam logic [7:0] TIMER_COUNT_REGISTER_IRQ_RESET      = 8'h00;
    localparam logic [1:0] TIMER_COUNT_REGISTER_WRITE_INHIBIT  = 2'h2;

    typedef struct packed {
        logic       run;
        logic       width8;
        logic       ext_source;
        logic       fall_edge;
        logic       bypass;
        logic [2:0] ratio;
    } timer_count_register_ctrl_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  addr;
    } timer_count_register_req_t;

endpackage : timer_count_register_pkg

//--- src/timer_count_register_prescaler.sv
// prescaler: eight-bit hidden divider producing a one-cycle tick
`timescale 1ns/10ps
`default_nettype none
module timer_count_register_prescaler
    import timer_count_register_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       clr,
    input  wire logic       inc,
    input  wire logic [2:0] ratio,
    output logic            tick
);

    typedef struct packed {
        logic [7:0] cnt;
    } timer_count_register_ps_state_t;

    timer_count_register_ps_state_t s_reg;
    timer_count_register_ps_state_t s_next;
    logic [7:0]     cnt_inc;
    logic [7:0]     mask;

    // ============================================================
    // divider; count not reachable from the bus
    always_comb
    begin
        s_next  = s_reg;
        cnt_inc = s_reg.cnt + 8'h01;
        mask    = 8'((9'h002 << ratio) - 9'h001);
        tick    = 1'b0;
        if (clr)
        begin
            s_next.cnt = 8'h00;
        end
        else if (inc)
        begin
            s_next.cnt = cnt_inc;
            tick       = ((s_reg.cnt & mask) == mask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    property p_clr_zero;
        @(posedge hclk) disable iff (!hresetn)
        clr |=> (s_reg.cnt == 8'h00);
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("prescaler not cleared");

    property p_ratio2_tick;
        @(posedge hclk) disable iff (!hresetn)
        (inc && !clr && ratio == 3'h0 && s_reg.cnt[0]) |-> tick;
    endproperty
    a_ratio2_tick: assert property (p_ratio2_tick) else $error("1:2 tick missing");

endmodule : timer_count_register_prescaler
`default_nettype wire

//--- src/timer_count_register_timer.sv
// timer top: ahb-lite slave, sync, counter, overflow interrupt
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module timer_count_register_timer
    import timer_count_register_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        external_count_pin,
    input  wire logic        sleep,
    output logic             irq
);

    // all state in one struct, filled by the one always_comb, held by the one always_ff
    typedef struct packed {
        timer_count_register_req_t   req;
        timer_count_register_ctrl_t  ctrl;
        logic [7:0]  cnt_lo;
        logic [7:0]  cnt_hi;
        logic [7:0]  hi_buf;
        logic        flag;
        logic        irq_en;
        logic [5:0]  irq_other;
        logic [1:0]  inhibit;
        logic        pin_meta;
        logic        pin_sync;
        logic        pin_prev;
        logic [31:0] rdata;
        logic        irq;
    } timer_count_register_state_t;

    // state copies and combinational helpers of the next-state logic
    timer_count_register_state_t s_reg;
    timer_count_register_state_t s_next;
    logic        ps_clr;
    logic        ps_inc;
    logic        ps_tick;
    logic        src_event;
    logic        edge_rise;
    logic        edge_fall;
    logic        step;
    logic        wr_low;
    logic        rd_low;
    logic        ovf;
    logic [15:0] cnt_plus;
    logic [7:0]  wbyte;
    logic        addr_hit;
    logic        wr_irq_ctrl;

    // ============================================================
    // prescaler instance
    timer_count_register_prescaler u_prescaler (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clr     (ps_clr),
        .inc     (ps_inc),
        .ratio   (s_reg.ctrl.ratio),
        .tick    (ps_tick)
    );

    // ============================================================
    // main next-state logic
    always_comb
    begin
        s_next   = s_reg;
        wbyte    = hwdata[7:0];
        // rising or falling edge on the synchronised pin
        edge_rise = s_reg.pin_sync & ~s_reg.pin_prev;
        edge_fall = ~s_reg.pin_sync & s_reg.pin_prev;
        src_event = s_reg.ctrl.ext_source ?
                    (s_reg.ctrl.fall_edge ? edge_fall : edge_rise) : 1'b1;
        // sleep gates the clock source, so no overflow can arise in sleep
        src_event = src_event & s_reg.ctrl.run & ~sleep;
        wr_low   = s_reg.req.valid & s_reg.req.write & (s_reg.req.addr == TIMER_COUNT_REGISTER_ADDR_COUNT_LOW);
        // data phase write to interrupt control, the only way software touches the flag
        wr_irq_ctrl = s_reg.req.valid & s_reg.req.write & (s_reg.req.addr == TIMER_COUNT_REGISTER_ADDR_IRQ_CONTROL);
        rd_low   = 1'b0;
        ps_clr   = wr_low & ~s_reg.ctrl.bypass;
        ps_inc   = src_event & ~s_reg.ctrl.bypass;
        // bypass bit read each cycle, so reassignment takes effect at once
        step     = (s_reg.ctrl.bypass ? src_event : ps_tick) & (s_reg.inhibit == 2'h0);
        cnt_plus = 16'({s_reg.cnt_hi, s_reg.cnt_lo} + 17'h00001);
        ovf      = 1'b0;

        // synchroniser: meta only feeds sync
        s_next.pin_meta = external_count_pin;
        s_next.pin_sync = s_reg.pin_meta;
        s_next.pin_prev = s_reg.pin_sync;

        if (s_reg.inhibit != 2'h0)
            s_next.inhibit = s_reg.inhibit - 2'h1;

        // counter advance
        if (step && !wr_low)
        begin
            if (s_reg.ctrl.width8)
            begin
                s_next.cnt_lo = cnt_plus[7:0];
                ovf           = (s_reg.cnt_lo == 8'hFF);
            end
            else
            begin
                s_next.cnt_lo = cnt_plus[7:0];
                s_next.cnt_hi = cnt_plus[15:8];
                ovf           = ({s_reg.cnt_hi, s_reg.cnt_lo} == 16'hFFFF);
            end
        end

        // data phase: write
        if (s_reg.req.valid && s_reg.req.write)
        begin
            if (s_reg.req.addr == TIMER_COUNT_REGISTER_ADDR_COUNT_LOW)
            begin
                s_next.cnt_lo  = wbyte;
                s_next.cnt_hi  = s_reg.ctrl.width8 ? s_reg.cnt_hi : s_reg.hi_buf;
                s_next.inhibit = TIMER_COUNT_REGISTER_WRITE_INHIBIT;
            end
            else if (s_reg.req.addr == TIMER_COUNT_REGISTER_ADDR_HIGH_BUFFER)
                s_next.hi_buf = wbyte;
            else if (s_reg.req.addr == TIMER_COUNT_REGISTER_ADDR_IRQ_CONTROL)
            begin
                s_next.irq_en    = wbyte[TIMER_COUNT_REGISTER_IRQ_ENABLE];
                s_next.flag      = wbyte[TIMER_COUNT_REGISTER_IRQ_FLAG];
                s_next.irq_other = {wbyte[7:6], wbyte[4:3], wbyte[1:0]};
            end
            else if (s_reg.req.addr == TIMER_COUNT_REGISTER_ADDR_TIMER_CTRL)
                s_next.ctrl = timer_count_register_ctrl_t'(wbyte);
        end

        // overflow sets the flag; set beats a simultaneous software clear
        if (ovf)
            s_next.flag = 1'b1;

        // address phase: capture and prepare read data; offsets above the map are
        // refused whole, so a stray address cannot alias onto the count register
        addr_hit         = hsel & hready & htrans[1] & (haddr[31:4] == 28'h0000000);
        s_next.req.valid = addr_hit;
        s_next.req.write = hwrite;
        s_next.req.addr  = haddr[3:0];
        s_next.rdata     = 32'h0000_0000;
        if (addr_hit && !hwrite)
        begin
            if (haddr[3:0] == TIMER_COUNT_REGISTER_ADDR_COUNT_LOW)
            begin
                rd_low       = 1'b1;
                s_next.rdata = {24'h000000, s_next.cnt_lo};
            end
            else if (haddr[3:0] == TIMER_COUNT_REGISTER_ADDR_HIGH_BUFFER)
                s_next.rdata = {24'h000000, s_next.hi_buf};
            else if (haddr[3:0] == TIMER_COUNT_REGISTER_ADDR_IRQ_CONTROL)
                s_next.rdata = {24'h000000, s_next.irq_other[5:4], s_next.irq_en,
                                s_next.irq_other[3:2], s_next.flag, s_next.irq_other[1:0]};
            else if (haddr[3:0] == TIMER_COUNT_REGISTER_ADDR_TIMER_CTRL)
                s_next.rdata = {24'h000000, s_next.ctrl};
        end
        if (rd_low && !s_reg.ctrl.width8)
            s_next.hi_buf = s_next.cnt_hi;

        s_next.irq = s_next.flag & s_next.irq_en;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_reg        <= '0;
            s_reg.ctrl   <= timer_count_register_ctrl_t'(TIMER_COUNT_REGISTER_CTRL_RESET);
            s_reg.hi_buf <= TIMER_COUNT_REGISTER_HIGH_RESET;
        end
        else
            s_reg <= s_next;
    end

    // ============================================================
    // read data and irq straight from flops; zero wait states, always okay
    assign hrdata    = s_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = s_reg.irq;

    // ============================================================
    // checks
    property p_irq_mask;
        @(posedge hclk) disable iff (!hresetn)
        !s_reg.irq_en |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

    property p_ovf8;
        @(posedge hclk) disable iff (!hresetn)
        (step && !wr_low && s_reg.ctrl.width8 && s_reg.cnt_lo == 8'hFF) |=> (s_reg.flag && s_reg.cnt_lo == 8'h00);
    endproperty
    a_ovf8: assert property (p_ovf8) else $error("8-bit wrap missed");

    property p_ovf16;
        @(posedge hclk) disable iff (!hresetn)
        (step && !wr_low && !s_reg.ctrl.width8 && {s_reg.cnt_hi, s_reg.cnt_lo} == 16'hFFFF)
        |=> (s_reg.flag && {s_reg.cnt_hi, s_reg.cnt_lo} == 16'h0000);
    endproperty
    a_ovf16: assert property (p_ovf16) else $error("16-bit wrap missed");

    property p_inhibit;
        @(posedge hclk) disable iff (!hresetn)
        wr_low |=> (s_reg.inhibit == 2'h2) ##1 (s_reg.inhibit == 2'h1 && $stable(s_reg.cnt_lo));
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("write inhibit wrong");

    property p_sleep;
        @(posedge hclk) disable iff (!hresetn)
        (sleep && !s_reg.req.valid) |=> $stable({s_reg.cnt_hi, s_reg.cnt_lo});
    endproperty
    a_sleep: assert property (p_sleep) else $error("counted in sleep");

    property p_hi_load;
        @(posedge hclk) disable iff (!hresetn)
        (wr_low && !s_reg.ctrl.width8) |=> (s_reg.cnt_hi == $past(s_reg.hi_buf));
    endproperty
    a_hi_load: assert property (p_hi_load) else $error("high byte not loaded");

    property p_hi_snap;
        @(posedge hclk) disable iff (!hresetn)
        (rd_low && !s_reg.ctrl.width8) |=> (s_reg.hi_buf == s_reg.cnt_hi);
    endproperty
    a_hi_snap: assert property (p_hi_snap) else $error("high buffer not captured");

    property p_ctrl_kept;
        @(posedge hclk) disable iff (!hresetn)
        wr_low |=> $stable(s_reg.ctrl);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept) else $error("control changed by count write");

    property p_bypass_step;
        @(posedge hclk) disable iff (!hresetn)
        (s_reg.ctrl.bypass && src_event && s_reg.inhibit == 2'h0 && !wr_low && s_reg.ctrl.width8)
        |=> (s_reg.cnt_lo == 8'($past(s_reg.cnt_lo) + 8'h01));
    endproperty
    a_bypass_step: assert property (p_bypass_step) else $error("bypass step missed");

    // ============================================================
    // checks on counter holds, prescaler clear, flag and irq behaviour
    // prescaler assigned and no tick: the count must not move
    property p_prescaled_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!s_reg.ctrl.bypass && !ps_tick && !wr_low) |=> $stable({s_reg.cnt_hi, s_reg.cnt_lo});
    endproperty
    a_prescaled_hold: assert property (p_prescaled_hold) else $error("count moved without prescaler tick");

    // counter mode with no pin edge: the count may not advance
    property p_no_edge_hold;
        @(posedge hclk) disable iff (!hresetn)
        (s_reg.ctrl.ext_source && (s_reg.pin_sync == s_reg.pin_prev) && !wr_low)
        |=> $stable({s_reg.cnt_hi, s_reg.cnt_lo});
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold) else $error("count moved without pin edge");

    // wrap with the interrupt enabled raises the line on the next cycle
    property p_irq_raise;
        @(posedge hclk) disable iff (!hresetn)
        (ovf && s_reg.irq_en && !wr_irq_ctrl) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("irq not raised on wrap");

    // a cleared prescaler cannot tick on the cycle after the clear
    property p_ps_cleared;
        @(posedge hclk) disable iff (!hresetn)
        ps_clr |=> !ps_tick;
    endproperty
    a_ps_cleared: assert property (p_ps_cleared) else $error("prescaler ticked after clear");

    // flag is sticky until software writes interrupt control
    property p_flag_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (s_reg.flag && !wr_irq_ctrl) |=> s_reg.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without write");

    // flag never sets without a wrap or a software write
    property p_flag_cause;
        @(posedge hclk) disable iff (!hresetn)
        (!s_reg.flag && !ovf && !wr_irq_ctrl) |=> !s_reg.flag;
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without wrap");

    // 8-bit mode: a low byte write leaves the high byte alone
    property p_hi_kept8;
        @(posedge hclk) disable iff (!hresetn)
        (wr_low && s_reg.ctrl.width8) |=> $stable(s_reg.cnt_hi);
    endproperty
    a_hi_kept8: assert property (p_hi_kept8) else $error("high byte changed in 8-bit mode");

    // both inhibit cycles after a count write hold the count still
    property p_inhibit_hold;
        @(posedge hclk) disable iff (!hresetn)
        (s_reg.inhibit != 2'h0 && !wr_low) |=> $stable({s_reg.cnt_hi, s_reg.cnt_lo});
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved during inhibit");

endmodule : timer_count_register_timer
`default_nettype wire

//--- test/timer_count_register_pin_model.sv
// count pin partner: drives the external count input like a slow outside source
`timescale 1ns/10ps
`default_nettype none
module timer_count_register_pin_model
(
    input  wire logic hclk,
    output var logic  external_count_pin
);
    // ============================================================
    // pin rests low so the first commanded change is a clean edge
    initial external_count_pin = 1'b0;

    // change just after an edge, then hold long enough for the two-flop sync
    task automatic set_level(input logic lvl, input int hold);
        @(posedge hclk);
        external_count_pin <= lvl;
        repeat (hold) @(posedge hclk);
    endtask : set_level
endmodule : timer_count_register_pin_model
`default_nettype wire

//--- test/timer_count_register_timer_tb.sv
// testbench for the timer: ahb-lite register tests, overflow irq, prescaler sweep
`timescale 1ns/10ps
`default_nettype none
module timer_count_register_timer_tb;
    import timer_count_register_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sleep, irq, pin;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  v, w;
    int          err_count, cmp_count;

    // ============================================================
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #50 hclk = ~hclk;

    timer_count_register_timer u_timer_count_register_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .external_count_pin(pin), .sleep(sleep), .irq(irq));
    timer_count_register_pin_model u_timer_count_register_pin_model (.hclk(hclk), .external_count_pin(pin));

    // ============================================================
    // verdict and end of run, also reached by any expired wait
    task automatic close_out();
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    // counts sampled through bus latency may be off by one tick
    task automatic near(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if ((got ^ got) !== 8'h00 || got < exp - 8'h01 || got > exp + 8'h01)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : near

    // bounded wait for bus ready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                $display("MISMATCH hready expected 1 seen %b", hready);
                err_count++;
                close_out();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    // one whole-word transfer: address phase held to ready, then data phase to ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        wait_ready();
        rd = hrdata[7:0];
        if (!wr)
            chk("rdata upper", 8'h00, hrdata[31:24] | hrdata[23:16] | hrdata[15:8]);
        chk("hresp", 8'h00, {7'h00, hresp});
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus(1'b0, a, 8'h00, d);
    endtask : rd

    // bounded wait for the interrupt line to rise
    task automatic wait_irq(input int bound);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < bound)
        begin
            @(posedge hclk);
            n++;
        end
        cmp_count++;
        if (irq !== 1'b1)
        begin
            $display("MISMATCH irq expected 1 seen %b", irq);
            err_count++;
            close_out();
        end
    endtask : wait_irq

    // ============================================================
    // main sequence
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, sleep, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h0C, v); chk("ctrl reset", TIMER_COUNT_REGISTER_CTRL_RESET, v);
        rd(8'h04, v); chk("high reset", TIMER_COUNT_REGISTER_HIGH_RESET, v);
        rd(8'h08, v); chk("irq reset", TIMER_COUNT_REGISTER_IRQ_RESET, v);
        wr(8'h10, 8'h55);
        rd(8'h10, v); chk("unmapped", 8'h00, v);
        // flag cleared before enabling, as service software must
        wr(8'h08, 8'h00);
        wr(8'h08, 8'h20);
        // 8-bit timer, bypassed, runs into FFh to 00h wrap
        wr(8'h0C, 8'hC8);
        wr(8'h00, 8'hFD);
        wait_irq(40);
        rd(8'h08, v); chk("flag set", 8'h24, v);
        wr(8'h08, 8'h04);
        repeat (2) @(posedge hclk);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(8'h08, 8'h00);
        rd(8'h08, v); chk("flag clear", 8'h00, v);
        wr(8'h08, 8'h20);
        repeat (2) @(posedge hclk);
        chk("irq idle", 8'h00, {7'h00, irq});
        // stopped 16-bit: buffered high byte loads and snapshots atomically
        wr(8'h0C, 8'h08);
        wr(8'h04, 8'h12);
        wr(8'h00, 8'h34);
        wr(8'h04, 8'h00);
        rd(8'h00, v); chk("low16", 8'h34, v);
        rd(8'h04, v); chk("high snap", 8'h12, v);
        // 16-bit wrap only from FFFFh
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'hF8);
        wr(8'h0C, 8'h88);
        wait_irq(40);
        wr(8'h0C, 8'h08);
        wr(8'h08, 8'h20);
        // prescaler sweep: eight ticks per ratio, ratio kept by count write
        for (int r = 0; r < 8; r++)
        begin
            wr(8'h0C, 8'hC0 | 8'(r));
            wr(8'h00, 8'h00);
            repeat (8 << (r + 1)) @(posedge hclk);
            rd(8'h00, v); near("prescaled", 8'h08, v);
            rd(8'h0C, v); chk("ctrl kept", 8'hC0 | 8'(r), v);
        end
        // sleep freezes the count
        wr(8'h0C, 8'hC8);
        sleep <= 1'b1;
        rd(8'h00, v);
        repeat (20) @(posedge hclk);
        rd(8'h00, w); chk("sleep hold", v, w);
        sleep <= 1'b0;
        // counter mode: rising then falling edge selection
        for (int e = 0; e < 2; e++)
        begin
            wr(8'h0C, 8'hE8 | (8'(e) << 4));
            wr(8'h00, 8'h00);
            u_timer_count_register_pin_model.set_level(1'b1, 8);
            rd(8'h00, v); chk("edge up", (e == 0) ? 8'h01 : 8'h00, v);
            u_timer_count_register_pin_model.set_level(1'b0, 8);
            rd(8'h00, v); chk("edge down", 8'h01, v);
        end
        close_out();
    end
endmodule : timer_count_register_timer_tb
`default_nettype wire
